// ===== verilog/cfsr_pkg.sv
// Package of offsets, field positions and types for the camera feature and status register bank
package cfsr_pkg;

    // ==========================================================
    // Register offsets (byte addresses, word aligned)
    localparam int CFSR_AW = 12;
    localparam logic [11:0] CFSR_OFS_TRG_LAT_CAP = 12'h534;
    localparam logic [11:0] CFSR_OFS_RSVD_HI_FIRST = 12'h538;
    localparam logic [11:0] CFSR_OFS_RSVD_HI_LAST = 12'h57C;
    localparam logic [11:0] CFSR_OFS_ZOOM_CAP = 12'h580;
    localparam logic [11:0] CFSR_OFS_PAN_CAP = 12'h584;
    localparam logic [11:0] CFSR_OFS_TILT_CAP = 12'h588;
    localparam logic [11:0] CFSR_OFS_LENS_FILTER_CAP = 12'h58C;
    localparam logic [11:0] CFSR_OFS_GRAB_DIM_CAP = 12'h5C0;
    localparam logic [11:0] CFSR_OFS_GRAB_FID_CAP = 12'h5C4;
    localparam logic [11:0] CFSR_OFS_FRAME_RATE = 12'h600;
    localparam logic [11:0] CFSR_OFS_VIDEO_MODE = 12'h604;
    localparam logic [11:0] CFSR_OFS_VIDEO_FORMAT = 12'h608;
    localparam logic [11:0] CFSR_OFS_ISO_CHAN_SPEED = 12'h60C;
    localparam logic [11:0] CFSR_OFS_SUPPLY_UNUSED = 12'h610;
    localparam logic [11:0] CFSR_OFS_CAPTURE_EN = 12'h614;
    localparam logic [11:0] CFSR_OFS_STORE_UNUSED = 12'h618;
    localparam logic [11:0] CFSR_OFS_SHOT_CTRL = 12'h61C;
    localparam logic [11:0] CFSR_OFS_STORE_CH_UNUSED = 12'h620;
    localparam logic [11:0] CFSR_OFS_ACT_CH_UNUSED = 12'h624;
    localparam logic [11:0] CFSR_OFS_FMT_ERR = 12'h628;
    localparam logic [11:0] CFSR_OFS_SW_TRIGGER = 12'h62C;

    // ==========================================================
    // Field positions as vector indices, not hardware numbering; hardware bit 0 of a word is bit 31 here
    localparam int CFSR_POS_PRESENT = 31;
    localparam int CFSR_POS_ABS = 30;
    localparam int CFSR_POS_ONE_PUSH = 28;
    localparam int CFSR_POS_READOUT = 27;
    localparam int CFSR_POS_ON_OFF = 26;
    localparam int CFSR_POS_AUTO = 25;
    localparam int CFSR_POS_MANUAL = 24;
    localparam int CFSR_MIN_LSB = 12;
    localparam int CFSR_MAX_LSB = 0;
    localparam int CFSR_CODE_LSB = 29;
    localparam int CFSR_CHAN_LSB = 28;
    localparam int CFSR_SPEED_LSB = 24;
    localparam int CFSR_FLAG_POS = 31;

    // ==========================================================
    // Values after reset
    localparam logic [2:0] CFSR_RST_CODE = 3'h0;
    localparam logic [3:0] CFSR_RST_CHAN = 4'h0;
    localparam logic [1:0] CFSR_RST_SPEED = 2'h0;
    localparam logic [31:0] CFSR_RST_SHOT = 32'h0;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        CFSR_TRG_IDLE = 2'b01,
        CFSR_TRG_ON = 2'b10
    } cfsr_trg_t;

    typedef struct packed {
        logic [2:0] frame_rate;
        logic [2:0] video_mode;
        logic [2:0] video_format;
        logic [3:0] iso_chan;
        logic [1:0] iso_speed;
        logic capture_en;
        logic [31:0] shot_ctrl;
        cfsr_trg_t trg;
        logic fmt_err;
        logic [31:0] rdata;
        logic rvalid;
        logic err;
    } cfsr_state_t;

    function automatic logic [31:0] cfsr_cap_word(input logic present, input logic abs_ctl,
                                                  input logic one_push, input logic readout,
                                                  input logic on_off, input logic auto_ctl,
                                                  input logic manual, input logic [11:0] min_v,
                                                  input logic [11:0] max_v);
        logic [31:0] w;
        w = 32'h0;
        w[CFSR_POS_PRESENT] = present;
        w[CFSR_POS_ABS] = abs_ctl;
        w[CFSR_POS_ONE_PUSH] = one_push;
        w[CFSR_POS_READOUT] = readout;
        w[CFSR_POS_ON_OFF] = on_off;
        w[CFSR_POS_AUTO] = auto_ctl;
        w[CFSR_POS_MANUAL] = manual;
        w[CFSR_MIN_LSB +: 12] = min_v;
        w[CFSR_MAX_LSB +: 12] = max_v;
        return w;
    endfunction

endpackage

// ===== verilog/cfsr_rdmux.sv
// Read data selection for the camera feature and status register bank
`timescale 1ns/100ps
module cfsr_rdmux
    import cfsr_pkg::*;
#(
    parameter logic [31:0] CAP_WORD = 32'h0
)
(
    input wire logic [11:0] addr_i,
    input wire logic [2:0] frame_rate_i,
    input wire logic [2:0] video_mode_i,
    input wire logic [2:0] video_format_i,
    input wire logic [3:0] iso_chan_i,
    input wire logic [1:0] iso_speed_i,
    input wire logic capture_en_i,
    input wire logic [31:0] shot_ctrl_i,
    input wire logic fmt_err_i,
    input wire logic busy_i,
    output logic [31:0] rdata_o
);

    // ==========================================================
    // Decode; inquiry words other than trigger latency, and reserved space, fall to zero
    always_comb
    begin
        rdata_o = 32'h0;
        case (addr_i)
            CFSR_OFS_TRG_LAT_CAP: rdata_o = CAP_WORD;
            CFSR_OFS_FRAME_RATE: rdata_o[CFSR_CODE_LSB +: 3] = frame_rate_i;
            CFSR_OFS_VIDEO_MODE: rdata_o[CFSR_CODE_LSB +: 3] = video_mode_i;
            CFSR_OFS_VIDEO_FORMAT: rdata_o[CFSR_CODE_LSB +: 3] = video_format_i;
            CFSR_OFS_ISO_CHAN_SPEED:
            begin
                rdata_o[CFSR_CHAN_LSB +: 4] = iso_chan_i;
                rdata_o[CFSR_SPEED_LSB +: 2] = iso_speed_i;
            end
            CFSR_OFS_CAPTURE_EN: rdata_o[CFSR_FLAG_POS] = capture_en_i;
            CFSR_OFS_SHOT_CTRL: rdata_o = shot_ctrl_i;
            CFSR_OFS_FMT_ERR: rdata_o[CFSR_FLAG_POS] = fmt_err_i;
            CFSR_OFS_SW_TRIGGER: rdata_o[CFSR_FLAG_POS] = busy_i;
            default: rdata_o = 32'h0;
        endcase
    end

endmodule

// ===== verilog/cfsr_regs.sv
// Camera feature capability, status and control register bank
// Operation
// - Capability bit 0 reports trigger latency present
// - Capability bit 1 reports absolute value control
// - Capability bit 4 reports value readout
// - Capability bit 5 reports on/off switching
// - Bits 6 and 7 report auto, manual control
// - Bits 8-19 minimum, bits 20-31 maximum setting
// - Offsets 538h to 57Ch reserved, read zero
// - Rate, mode, format codes in bits 0-2
// - Channel in bits 0-3, speed 6-7
// - Continuous capture bit 0: 1 starts, 0 stops
// - Trigger word: 1 asserts, 0 withdraws
// - Edge mode self-clears; level needs host 0
// - Trigger read: 0 ready, 1 busy
`timescale 1ns/100ps
module cfsr_regs
    import cfsr_pkg::*;
#(
    parameter logic CAP_PRESENT = 1'b1,
    parameter logic CAP_ABS = 1'b0,
    parameter logic CAP_ONE_PUSH = 1'b0,
    parameter logic CAP_READOUT = 1'b1,
    parameter logic CAP_ON_OFF = 1'b1,
    parameter logic CAP_AUTO = 1'b0,
    parameter logic CAP_MANUAL = 1'b1,
    parameter logic [11:0] CAP_MIN = 12'h000,
    parameter logic [11:0] CAP_MAX = 12'hFFF
)
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic edge_mode_i,
    input wire logic camera_busy_i,
    input wire logic format_error_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic reg_err_o,
    output logic [2:0] frame_rate_o,
    output logic [2:0] video_mode_o,
    output logic [2:0] video_format_o,
    output logic [3:0] iso_chan_o,
    output logic [1:0] iso_speed_o,
    output logic capture_en_o,
    output logic [31:0] shot_ctrl_o,
    output logic sw_trigger_o
);

    // ==========================================================
    // Capability word, fixed at elaboration
    localparam logic [31:0] CAP_WORD = cfsr_cap_word(CAP_PRESENT, CAP_ABS, CAP_ONE_PUSH, CAP_READOUT,
                                                     CAP_ON_OFF, CAP_AUTO, CAP_MANUAL, CAP_MIN, CAP_MAX);

    if (CAP_MIN > CAP_MAX)
    begin : g_bad_range
        $error("cfsr_regs: minimum setting above maximum");
    end

    // ==========================================================
    // State
    cfsr_state_t cur_ff;
    cfsr_state_t nxt_ff;
    logic aligned;
    logic wr_ok;
    logic busy;
    logic [31:0] rd_word;

    assign aligned = (reg_addr_i[1:0] == 2'b00);
    assign wr_ok = reg_wr_i && aligned;
    // Busy covers both a pending host trigger and the exposure engine
    assign busy = (cur_ff.trg == CFSR_TRG_ON) || camera_busy_i;

    cfsr_rdmux #(
        .CAP_WORD(CAP_WORD)
    ) u_rdmux (
        .addr_i(reg_addr_i),
        .frame_rate_i(cur_ff.frame_rate),
        .video_mode_i(cur_ff.video_mode),
        .video_format_i(cur_ff.video_format),
        .iso_chan_i(cur_ff.iso_chan),
        .iso_speed_i(cur_ff.iso_speed),
        .capture_en_i(cur_ff.capture_en),
        .shot_ctrl_i(cur_ff.shot_ctrl),
        .fmt_err_i(cur_ff.fmt_err),
        .busy_i(busy),
        .rdata_o(rd_word)
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        nxt_ff = cur_ff;
        nxt_ff.fmt_err = format_error_i;
        nxt_ff.err = (reg_wr_i || reg_rd_i) && !aligned;
        nxt_ff.rvalid = reg_rd_i;
        // Misaligned reads answer zero rather than a neighbour's contents
        nxt_ff.rdata = (reg_rd_i && aligned) ? rd_word : 32'h0;
        if (wr_ok)
        begin
            case (reg_addr_i)
                CFSR_OFS_FRAME_RATE: nxt_ff.frame_rate = reg_wdata_i[CFSR_CODE_LSB +: 3];
                CFSR_OFS_VIDEO_MODE: nxt_ff.video_mode = reg_wdata_i[CFSR_CODE_LSB +: 3];
                CFSR_OFS_VIDEO_FORMAT: nxt_ff.video_format = reg_wdata_i[CFSR_CODE_LSB +: 3];
                CFSR_OFS_ISO_CHAN_SPEED:
                begin
                    nxt_ff.iso_chan = reg_wdata_i[CFSR_CHAN_LSB +: 4];
                    nxt_ff.iso_speed = reg_wdata_i[CFSR_SPEED_LSB +: 2];
                end
                CFSR_OFS_CAPTURE_EN: nxt_ff.capture_en = reg_wdata_i[CFSR_FLAG_POS];
                CFSR_OFS_SHOT_CTRL: nxt_ff.shot_ctrl = reg_wdata_i;
                default: nxt_ff.shot_ctrl = cur_ff.shot_ctrl;
            endcase
        end
        // Trigger: a host write wins over the self-clear in the same cycle
        case (cur_ff.trg)
            CFSR_TRG_IDLE:
            begin
                if (wr_ok && reg_addr_i == CFSR_OFS_SW_TRIGGER && reg_wdata_i[CFSR_FLAG_POS])
                begin
                    nxt_ff.trg = CFSR_TRG_ON;
                end
            end
            CFSR_TRG_ON:
            begin
                if (wr_ok && reg_addr_i == CFSR_OFS_SW_TRIGGER)
                begin
                    nxt_ff.trg = reg_wdata_i[CFSR_FLAG_POS] ? CFSR_TRG_ON : CFSR_TRG_IDLE;
                end
                else if (edge_mode_i)
                begin
                    nxt_ff.trg = CFSR_TRG_IDLE;
                end
            end
            default: nxt_ff.trg = CFSR_TRG_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cur_ff.frame_rate <= CFSR_RST_CODE;
            cur_ff.video_mode <= CFSR_RST_CODE;
            cur_ff.video_format <= CFSR_RST_CODE;
            cur_ff.iso_chan <= CFSR_RST_CHAN;
            cur_ff.iso_speed <= CFSR_RST_SPEED;
            cur_ff.capture_en <= 1'b0;
            cur_ff.shot_ctrl <= CFSR_RST_SHOT;
            cur_ff.trg <= CFSR_TRG_IDLE;
            cur_ff.fmt_err <= 1'b0;
            cur_ff.rdata <= 32'h0;
            cur_ff.rvalid <= 1'b0;
            cur_ff.err <= 1'b0;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata_o = cur_ff.rdata;
    assign reg_rvalid_o = cur_ff.rvalid;
    assign reg_err_o = cur_ff.err;
    assign frame_rate_o = cur_ff.frame_rate;
    assign video_mode_o = cur_ff.video_mode;
    assign video_format_o = cur_ff.video_format;
    assign iso_chan_o = cur_ff.iso_chan;
    assign iso_speed_o = cur_ff.iso_speed;
    assign capture_en_o = cur_ff.capture_en;
    assign shot_ctrl_o = cur_ff.shot_ctrl;
    // One-hot ON bit taken straight from its flop, no decode on the pin
    assign sw_trigger_o = cur_ff.trg[1];

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    logic cap_rd;
    assign cap_rd = reg_rd_i && reg_addr_i == CFSR_OFS_TRG_LAT_CAP;

    chk_cap_present: assert property (cap_rd |=> reg_rvalid_o && reg_rdata_o[31] == CAP_PRESENT)
        else $error("presence flag wrong");
    chk_cap_abs: assert property (cap_rd |=> reg_rdata_o[30] == CAP_ABS)
        else $error("absolute control flag wrong");
    chk_cap_readout: assert property (cap_rd |=> reg_rdata_o[27] == CAP_READOUT)
        else $error("readout flag wrong");
    chk_cap_onoff: assert property (cap_rd |=> reg_rdata_o[26] == CAP_ON_OFF)
        else $error("on/off flag wrong");
    chk_cap_auto_manual: assert property (cap_rd |=> reg_rdata_o[25:24] == {CAP_AUTO, CAP_MANUAL})
        else $error("auto/manual flags wrong");
    chk_cap_range: assert property (cap_rd |=> reg_rdata_o[23:12] == CAP_MIN && reg_rdata_o[11:0] == CAP_MAX)
        else $error("min/max fields wrong");
    chk_rsvd_zero: assert property (reg_rd_i && reg_addr_i >= CFSR_OFS_RSVD_HI_FIRST
                                    && reg_addr_i <= CFSR_OFS_RSVD_HI_LAST |=> reg_rdata_o == 32'h0)
        else $error("reserved word not zero");
    chk_rate_write: assert property (wr_ok && reg_addr_i == CFSR_OFS_FRAME_RATE
                                     |=> frame_rate_o == $past(reg_wdata_i[31:29]))
        else $error("frame rate code not taken from bits 0-2");
    chk_iso_write: assert property (wr_ok && reg_addr_i == CFSR_OFS_ISO_CHAN_SPEED
                                    |=> iso_chan_o == $past(reg_wdata_i[31:28]) && iso_speed_o == $past(reg_wdata_i[25:24]))
        else $error("channel or speed field misplaced");
    chk_capture_en: assert property (wr_ok && reg_addr_i == CFSR_OFS_CAPTURE_EN
                                     |=> capture_en_o == $past(reg_wdata_i[31]))
        else $error("continuous capture not following bit 0");
    chk_trg_write: assert property (wr_ok && reg_addr_i == CFSR_OFS_SW_TRIGGER
                                    |=> sw_trigger_o == $past(reg_wdata_i[31]))
        else $error("software trigger not following write");
    chk_edge_clear: assert property (sw_trigger_o && edge_mode_i && !(reg_wr_i && reg_addr_i == CFSR_OFS_SW_TRIGGER)
                                     |=> !sw_trigger_o)
        else $error("edge trigger did not self-clear");
    chk_level_hold: assert property (sw_trigger_o && !edge_mode_i && !(reg_wr_i && reg_addr_i == CFSR_OFS_SW_TRIGGER)
                                     |=> sw_trigger_o)
        else $error("level trigger dropped without host");
    chk_busy_read: assert property (reg_rd_i && reg_addr_i == CFSR_OFS_SW_TRIGGER
                                    |=> reg_rdata_o == {$past(sw_trigger_o || camera_busy_i), 31'h0})
        else $error("busy readback wrong");
    chk_misaligned: assert property (reg_wr_i && reg_addr_i[1:0] != 2'b00
                                     |=> reg_err_o && $stable(frame_rate_o) && $stable(capture_en_o) && $stable(iso_chan_o))
        else $error("misaligned write had effect");

    cov_edge_pulse: cover property (edge_mode_i && !sw_trigger_o ##1 sw_trigger_o ##1 !sw_trigger_o);
    cov_level_hold: cover property (!edge_mode_i && sw_trigger_o [*3] ##1 !sw_trigger_o);
    cov_busy_read: cover property (reg_rd_i && reg_addr_i == CFSR_OFS_SW_TRIGGER && busy);
    cov_capture_on: cover property (!capture_en_o ##1 capture_en_o);

endmodule

// ===== test/cfsr_host_model.sv
// Host side model issuing whole-word register accesses
`timescale 1ns/100ps
module cfsr_host_model
(
    input wire logic mclk_i,
    input wire logic [31:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    input wire logic reg_err_i,
    output logic [11:0] reg_addr_o,
    output logic [31:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o
);
    // ==========================================================
    // Idle bus; address and data scrambled so stale values never help
    initial
    begin
        reg_addr_o = 12'hFFF;
        reg_wdata_o = 32'hA5A5A5A5;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // ==========================================================
    // One access per call; answer taken one edge after the strobe
    task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                          output logic [31:0] rdata, output logic rvalid, output logic err);
        @(posedge mclk_i);
        #1;
        reg_wr_o = wr;
        reg_rd_o = !wr;
        reg_addr_o = addr;
        reg_wdata_o = data;
        @(posedge mclk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
        reg_wdata_o = ~data;
        rdata = reg_rdata_i;
        rvalid = reg_rvalid_i;
        err = reg_err_i;
    endtask
endmodule

// ===== test/cfsr_regs_tb_top.sv
// Self-checking testbench of the camera feature and status register bank
`timescale 1ns/100ps
module cfsr_regs_tb_top;
    import cfsr_pkg::*;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic edge_mode = 1'b1;
    logic camera_busy = 1'b0;
    logic format_error = 1'b0;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic rvalid;
    logic err;
    logic [2:0] frame_rate;
    logic [2:0] video_mode;
    logic [2:0] video_format;
    logic [3:0] iso_chan;
    logic [1:0] iso_speed;
    logic capture_en;
    logic [31:0] shot_ctrl;
    logic sw_trigger;
    int miscompares = 0;
    int n_compared = 0;
    logic [11:0] zero_ofs [14] = '{12'h538, 12'h57C, 12'h580, 12'h584, 12'h588, 12'h58C, 12'h590,
        12'h5C0, 12'h5C4, 12'h610, 12'h618, 12'h620, 12'h624, 12'h7FC};

    // ==========================================================
    // Clock and instances; capability parameters off default to expose field slips
    initial
    begin
        forever #10 mclk_i = ~mclk_i;
    end

    cfsr_regs #(.CAP_ABS(1'b1), .CAP_AUTO(1'b1), .CAP_MANUAL(1'b0), .CAP_MIN(12'h123),
        .CAP_MAX(12'hABC)) i_cfsr_regs (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .edge_mode_i(edge_mode),
        .camera_busy_i(camera_busy), .format_error_i(format_error), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .reg_err_o(err), .frame_rate_o(frame_rate), .video_mode_o(video_mode),
        .video_format_o(video_format), .iso_chan_o(iso_chan), .iso_speed_o(iso_speed),
        .capture_en_o(capture_en), .shot_ctrl_o(shot_ctrl), .sw_trigger_o(sw_trigger));

    cfsr_host_model i_cfsr_host_model (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
        .reg_err_i(err), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

    // ==========================================================
    // Compare, access and closing tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] q;
        logic v;
        logic e;
        i_cfsr_host_model.access(1'b1, a, d, q, v, e);
        chk({31'h0, e}, {31'h0, exp_err}, "write error flag");
    endtask

    task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic v;
        logic e;
        i_cfsr_host_model.access(1'b0, a, 32'h0, q, v, e);
        chk({31'h0, v}, 32'h1, "read valid");
        chk(q, exp, "read data");
        chk({31'h0, e}, {31'h0, exp_err}, "read error flag");
    endtask

    task automatic results();
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Cut a hang short
    initial
    begin
        #1000000;
        miscompares++;
        results();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (4) @(posedge mclk_i);
        #1;
        nrst_i = 1'b1;
        chk({15'h0, frame_rate, video_mode, video_format, iso_chan, iso_speed, capture_en, sw_trigger},
            32'h0, "reset outputs");
        rd_reg(CFSR_OFS_TRG_LAT_CAP, 32'hCE123ABC, 1'b0);
        wr_reg(CFSR_OFS_TRG_LAT_CAP, 32'h0, 1'b0);
        rd_reg(CFSR_OFS_TRG_LAT_CAP, 32'hCE123ABC, 1'b0);
        foreach (zero_ofs[i])
        begin
            wr_reg(zero_ofs[i], 32'hFFFFFFFF, 1'b0);
            rd_reg(zero_ofs[i], 32'h0, 1'b0);
        end
        for (int c = 0; c < 8; c++)
        begin
            wr_reg(CFSR_OFS_FRAME_RATE, {3'(c), 29'h1FFFFFFF}, 1'b0);
            wr_reg(CFSR_OFS_VIDEO_MODE, {~3'(c), 29'h1FFFFFFF}, 1'b0);
            wr_reg(CFSR_OFS_VIDEO_FORMAT, {3'(c + 3), 29'h0}, 1'b0);
            chk({23'h0, frame_rate, video_mode, video_format}, {23'h0, 3'(c), ~3'(c), 3'(c + 3)}, "codes");
            rd_reg(CFSR_OFS_FRAME_RATE, {3'(c), 29'h0}, 1'b0);
            rd_reg(CFSR_OFS_VIDEO_MODE, {~3'(c), 29'h0}, 1'b0);
            rd_reg(CFSR_OFS_VIDEO_FORMAT, {3'(c + 3), 29'h0}, 1'b0);
        end
        wr_reg(CFSR_OFS_ISO_CHAN_SPEED, 32'hAEFFFFFF, 1'b0);
        chk({26'h0, iso_chan, iso_speed}, 32'h2A, "channel and speed");
        rd_reg(CFSR_OFS_ISO_CHAN_SPEED, 32'hA2000000, 1'b0);
        wr_reg(CFSR_OFS_ISO_CHAN_SPEED, 32'h51000000, 1'b0);
        rd_reg(CFSR_OFS_ISO_CHAN_SPEED, 32'h51000000, 1'b0);
        wr_reg(CFSR_OFS_CAPTURE_EN, 32'h80000000, 1'b0);
        chk({31'h0, capture_en}, 32'h1, "capture start");
        rd_reg(CFSR_OFS_CAPTURE_EN, 32'h80000000, 1'b0);
        wr_reg(CFSR_OFS_CAPTURE_EN, 32'h7FFFFFFF, 1'b0);
        chk({31'h0, capture_en}, 32'h0, "capture stop");
        wr_reg(CFSR_OFS_CAPTURE_EN + 12'h2, 32'h80000000, 1'b1);
        chk({31'h0, capture_en}, 32'h0, "misaligned write ignored");
        rd_reg(CFSR_OFS_TRG_LAT_CAP + 12'h1, 32'h0, 1'b1);
        wr_reg(CFSR_OFS_SHOT_CTRL, 32'h12345678, 1'b0);
        chk(shot_ctrl, 32'h12345678, "shot word");
        rd_reg(CFSR_OFS_SHOT_CTRL, 32'h12345678, 1'b0);
        format_error = 1'b1;
        rd_reg(CFSR_OFS_FMT_ERR, 32'h80000000, 1'b0);
        format_error = 1'b0;
        rd_reg(CFSR_OFS_FMT_ERR, 32'h0, 1'b0);
        wr_reg(CFSR_OFS_SW_TRIGGER, 32'h80000000, 1'b0);
        chk({31'h0, sw_trigger}, 32'h1, "edge trigger set");
        @(posedge mclk_i);
        #1;
        chk({31'h0, sw_trigger}, 32'h0, "edge trigger self clear");
        rd_reg(CFSR_OFS_SW_TRIGGER, 32'h0, 1'b0);
        edge_mode = 1'b0;
        wr_reg(CFSR_OFS_SW_TRIGGER, 32'h80000000, 1'b0);
        repeat (3) @(posedge mclk_i);
        #1;
        chk({31'h0, sw_trigger}, 32'h1, "level trigger holds");
        rd_reg(CFSR_OFS_SW_TRIGGER, 32'h80000000, 1'b0);
        wr_reg(CFSR_OFS_SW_TRIGGER, 32'h0, 1'b0);
        chk({31'h0, sw_trigger}, 32'h0, "level trigger withdrawn");
        rd_reg(CFSR_OFS_SW_TRIGGER, 32'h0, 1'b0);
        camera_busy = 1'b1;
        rd_reg(CFSR_OFS_SW_TRIGGER, 32'h80000000, 1'b0);
        camera_busy = 1'b0;
        wr_reg(CFSR_OFS_CAPTURE_EN, 32'h80000000, 1'b0);
        nrst_i = 1'b0;
        #1;
        chk({15'h0, frame_rate, video_mode, video_format, iso_chan, iso_speed, capture_en, sw_trigger},
            32'h0, "mid-run reset");
        @(posedge mclk_i);
        #1;
        nrst_i = 1'b1;
        rd_reg(CFSR_OFS_CAPTURE_EN, 32'h0, 1'b0);
        results();
    end
endmodule
